// file: smbesc_top.v
`timescale 1ns/1ps
`include "smbesc_defs.vh"
module smbesc_top #(
    parameter TIMEOUT_CYC = `SMBESC_TIMEOUT_CYC,
    parameter LW = 5
) (
    input wire MCLK,
    input wire RST_N,
    input wire [7:0] SFR_ADDR,
    input wire [7:0] SFR_WDATA,
    input wire SFR_WR,
    input wire SFR_RD,
    output reg [7:0] SFR_RDATA,
    input wire [7:0] EVENT_ENABLE,
    input wire [1:0] THRESHOLD_SEL,
    input wire [LW-1:0] RX_LEVEL,
    input wire [LW-1:0] TX_LEVEL,
    input wire TX_SHIFTER_EMPTY,
    input wire [2:0] MODE,
    input wire ADDRESS_MATCH,
    input wire RX_PACKAGE_END,
    input wire BUS_FAIL,
    input wire BUS_COLLISION,
    input wire DEVICE_ERROR,
    input wire [4:0] FIFO_STATE,
    input wire [3:0] SYSTEM_STATE,
    input wire SCL_IN,
    input wire SDA_IN,
    output reg IRQ,
    output reg LINE_IRQ,
    output reg SOFT_RESET,
    output reg TIMEOUT
);

////////////////////////////////////////////////////////////////////////
// Threshold decode
function [LW-1:0] thr_level;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: thr_level = 5'h01;
            2'h1: thr_level = 5'h04;
            2'h2: thr_level = 5'h08;
            default: thr_level = 5'h0d;
        endcase
    end
endfunction

function is_addr;
    input [7:0] a;
    input [7:0] ref_a;
    begin
        is_addr = (a == ref_a);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Register state
reg [6:0] flags_q;
reg [6:0] flags_d;
reg [7:0] scratch_q;
reg edge_sel_q;
reg line_sel_q;
reg short_test_q;
reg addr_hit_q;
reg rx_nonempty_q;
reg tx_empty_q;
reg tx_below_q;
reg rx_above_q;
reg [7:0] rdata_d;
wire wr_event;
wire wr_line;
wire soft_fire;
wire rx_nonempty;
wire tx_empty;
wire tx_below;
wire rx_above;
wire [6:0] set_vec;
wire [2:0] fifo_stat;

assign wr_event = SFR_WR && is_addr(SFR_ADDR, `SMBESC_ADDR_EVENT);
assign wr_line = SFR_WR && is_addr(SFR_ADDR, `SMBESC_ADDR_LINE);
assign soft_fire = wr_line && SFR_WDATA[`SMBESC_BIT_SRST];
assign rx_nonempty = (RX_LEVEL != 5'h00);
assign tx_empty = (TX_LEVEL == 5'h00);
assign tx_below = (TX_LEVEL < thr_level(THRESHOLD_SEL));
assign rx_above = (RX_LEVEL > thr_level(THRESHOLD_SEL));

////////////////////////////////////////////////////////////////////////
// Bus line sampling
reg scl_s1_q;
reg scl_s2_q;
reg scl_s3_q;
reg sda_s1_q;
reg sda_s2_q;
reg sda_s3_q;
wire start_det;
wire stop_det;
wire scl_rise;
wire line_now;
wire line_old;
wire line_edge;

always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
        scl_s1_q <= 1'b1;
        scl_s2_q <= 1'b1;
        scl_s3_q <= 1'b1;
        sda_s1_q <= 1'b1;
        sda_s2_q <= 1'b1;
        sda_s3_q <= 1'b1;
    end else begin
        scl_s1_q <= SCL_IN;
        scl_s2_q <= scl_s1_q;
        scl_s3_q <= scl_s2_q;
        sda_s1_q <= SDA_IN;
        sda_s2_q <= sda_s1_q;
        sda_s3_q <= sda_s2_q;
    end
end

assign start_det = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
assign stop_det = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
assign scl_rise = scl_s2_q && !scl_s3_q;
assign line_now = line_sel_q ? scl_s2_q : sda_s2_q;
assign line_old = line_sel_q ? scl_s3_q : sda_s3_q;
assign line_edge = edge_sel_q ? (line_now && !line_old) :
                   (!line_now && line_old);

////////////////////////////////////////////////////////////////////////
// Bus state and timeout
reg idle_q;
reg start_seen_q;
reg stop_seen_q;
reg [15:0] to_cnt_q;
reg [4:0] scl_cnt_q;
reg to_done_q;
wire busy;
wire to_hit;

assign busy = start_seen_q && !to_done_q;
assign to_hit = short_test_q ?
    (scl_rise && scl_cnt_q == `SMBESC_SHORT_SCL - 5'h01) :
    (to_cnt_q == TIMEOUT_CYC[15:0] - 16'h0001);

always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
        idle_q <= 1'b0;
        start_seen_q <= 1'b0;
        stop_seen_q <= 1'b0;
        to_cnt_q <= 16'h0000;
        scl_cnt_q <= 5'h00;
        to_done_q <= 1'b0;
        TIMEOUT <= 1'b0;
    end else if (SOFT_RESET) begin
        idle_q <= 1'b0;
        start_seen_q <= 1'b0;
        stop_seen_q <= 1'b0;
        to_cnt_q <= 16'h0000;
        scl_cnt_q <= 5'h00;
        to_done_q <= 1'b0;
        TIMEOUT <= 1'b0;
    end else begin
        TIMEOUT <= 1'b0;
        if (start_det) begin
            start_seen_q <= 1'b1;
            stop_seen_q <= 1'b0;
            idle_q <= 1'b0;
            to_cnt_q <= 16'h0000;
            scl_cnt_q <= 5'h00;
            to_done_q <= 1'b0;
        end else if (stop_det) begin
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b1;
            idle_q <= 1'b1;
        end else if (!start_seen_q && scl_s2_q && sda_s2_q) begin
            idle_q <= 1'b1;
        end
        if (busy && !start_det) begin
            to_cnt_q <= to_cnt_q + 16'h0001;
            if (scl_rise) begin
                scl_cnt_q <= scl_cnt_q + 5'h01;
            end
            if (to_hit) begin
                to_done_q <= 1'b1;
                TIMEOUT <= 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Event flags
// RX non-empty, TX empty and threshold sources take edges so a cleared flag is not set again at once; address, end, error and RX byte's address hit are levels
assign set_vec[`SMBESC_BIT_RX_BYTE_AVAILABLE] = (rx_nonempty && !rx_nonempty_q) ||
                                    addr_hit_q;
assign set_vec[`SMBESC_BIT_ADDR] = ADDRESS_MATCH;
assign set_vec[`SMBESC_BIT_END] = RX_PACKAGE_END;
assign set_vec[`SMBESC_BIT_ERR] = BUS_FAIL || BUS_COLLISION ||
                                  DEVICE_ERROR || TIMEOUT;
assign set_vec[`SMBESC_BIT_TXEMP] = tx_empty && !tx_empty_q;
assign set_vec[`SMBESC_BIT_TXTH] = tx_below && !tx_below_q;
assign set_vec[`SMBESC_BIT_RXTH] = rx_above && !rx_above_q;

always @* begin
    flags_d = flags_q;
    if (wr_event) begin
        flags_d = flags_q & ~SFR_WDATA[6:0];
    end
    // Set beats a clear landing in the same cycle
    flags_d = flags_d | (set_vec & EVENT_ENABLE[6:0]);
end

always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
        flags_q <= `SMBESC_RST_FLAGS;
        addr_hit_q <= 1'b0;
        rx_nonempty_q <= 1'b0;
        tx_empty_q <= 1'b1;
        tx_below_q <= 1'b1;
        rx_above_q <= 1'b0;
        IRQ <= 1'b0;
    end else if (SOFT_RESET) begin
        flags_q <= `SMBESC_RST_FLAGS;
        addr_hit_q <= 1'b0;
        rx_nonempty_q <= 1'b0;
        tx_empty_q <= 1'b1;
        tx_below_q <= 1'b1;
        rx_above_q <= 1'b0;
        IRQ <= 1'b0;
    end else begin
        flags_q <= flags_d;
        addr_hit_q <= ADDRESS_MATCH && EVENT_ENABLE[`SMBESC_BIT_ADDR];
        rx_nonempty_q <= rx_nonempty;
        tx_empty_q <= tx_empty;
        tx_below_q <= tx_below;
        rx_above_q <= rx_above;
        IRQ <= (|flags_d) && EVENT_ENABLE[`SMBESC_BIT_GLOBAL];
    end
end

////////////////////////////////////////////////////////////////////////
// Control registers and soft reset
always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
        scratch_q <= `SMBESC_RST_SCRATCH;
        edge_sel_q <= `SMBESC_RST_EDGE;
        line_sel_q <= 1'b0;
        short_test_q <= 1'b0;
        SOFT_RESET <= 1'b0;
        LINE_IRQ <= 1'b0;
    end else begin
        SOFT_RESET <= soft_fire;
        LINE_IRQ <= line_edge && !SOFT_RESET;
        if (SFR_WR && is_addr(SFR_ADDR, `SMBESC_ADDR_SCRATCH)) begin
            scratch_q <= SFR_WDATA;
        end
        if (wr_line) begin
            edge_sel_q <= SFR_WDATA[`SMBESC_BIT_EDGE];
            line_sel_q <= SFR_WDATA[`SMBESC_BIT_LSEL];
        end
        if (SFR_WR && is_addr(SFR_ADDR, `SMBESC_ADDR_DBG1)) begin
            short_test_q <= SFR_WDATA[`SMBESC_BIT_SHORT];
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Read path
// Status is live so software never sees a stale empty bit
assign fifo_stat[2] = TX_SHIFTER_EMPTY;
assign fifo_stat[1] = tx_empty;
assign fifo_stat[0] = rx_nonempty && (MODE == `SMBESC_MODE_MRX ||
                      MODE == `SMBESC_MODE_SRX);

always @* begin
    rdata_d = 8'h00;
    case (SFR_ADDR)
        `SMBESC_ADDR_EVENT: rdata_d = {1'b0, flags_q};
        `SMBESC_ADDR_FIFO: rdata_d = {5'h00, fifo_stat};
        `SMBESC_ADDR_SCRATCH: rdata_d = scratch_q;
        `SMBESC_ADDR_LINE: rdata_d = {edge_sel_q, line_sel_q, 6'h00};
        `SMBESC_ADDR_DBG0: rdata_d = {idle_q, start_seen_q, stop_seen_q,
                                      FIFO_STATE};
        `SMBESC_ADDR_DBG1: rdata_d = {SYSTEM_STATE, 3'h0,
                                      short_test_q};
        default: rdata_d = 8'h00;
    endcase
end

always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
        SFR_RDATA <= 8'h00;
    end else if (SFR_RD) begin
        SFR_RDATA <= rdata_d;
    end
end

endmodule // smbesc_top

// file: smbesc_defs.vh
`ifndef SMBESC_DEFS_VH
`define SMBESC_DEFS_VH
`define SMBESC_ADDR_EVENT 8'h30
`define SMBESC_ADDR_FIFO 8'h31
`define SMBESC_ADDR_SCRATCH 8'h32
`define SMBESC_ADDR_LINE 8'h33
`define SMBESC_ADDR_DBG0 8'h34
`define SMBESC_ADDR_DBG1 8'h35
`define SMBESC_RST_EVENT 8'h00
`define SMBESC_RST_FLAGS 7'h00
`define SMBESC_RST_EDGE 1'b1
`define SMBESC_RST_FIFO 8'h06
`define SMBESC_RST_SCRATCH 8'h00
`define SMBESC_RST_LINE 8'h80
`define SMBESC_BIT_RX_BYTE_AVAILABLE 6
`define SMBESC_BIT_ADDR 5
`define SMBESC_BIT_END 4
`define SMBESC_BIT_ERR 3
`define SMBESC_BIT_TXEMP 2
`define SMBESC_BIT_TXTH 1
`define SMBESC_BIT_RXTH 0
`define SMBESC_BIT_GLOBAL 7
`define SMBESC_BIT_EDGE 7
`define SMBESC_BIT_LSEL 6
`define SMBESC_BIT_SRST 0
`define SMBESC_BIT_SHORT 0
`define SMBESC_MODE_MRX 3'h5
`define SMBESC_MODE_SRX 3'h7
`define SMBESC_TIMEOUT_US 1000
`define SMBESC_CLK_MHZ 40
`define SMBESC_TIMEOUT_CYC (`SMBESC_TIMEOUT_US * `SMBESC_CLK_MHZ)
`define SMBESC_SHORT_SCL 5'd24
`endif

// file: smbesc_chk_asserts.sv
`timescale 1ns/1ps
module smbesc_chk #(parameter LW = 5) (
    input wire MCLK,
    input wire RST_N,
    input wire [7:0] SFR_ADDR,
    input wire [7:0] SFR_WDATA,
    input wire SFR_WR,
    input wire SFR_RD,
    input wire [7:0] SFR_RDATA,
    input wire [7:0] EVENT_ENABLE,
    input wire [LW-1:0] TX_LEVEL,
    input wire TX_SHIFTER_EMPTY,
    input wire ADDRESS_MATCH,
    input wire BUS_FAIL,
    input wire [4:0] FIFO_STATE,
    input wire IRQ,
    input wire SOFT_RESET
);
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////
    // IRQ is registered, so it answers the enable seen one edge earlier
    a_irq_global: assert property (IRQ |-> $past(EVENT_ENABLE[7]))
        else $error("irq without global enable");
    a_fail_irq: assert property (BUS_FAIL && EVENT_ENABLE[3]
        && EVENT_ENABLE[7] |-> ##[1:2] IRQ) else $error("fail no irq");
    a_addr_irq: assert property (ADDRESS_MATCH && EVENT_ENABLE[5]
        && EVENT_ENABLE[7] |-> ##[1:2] IRQ) else $error("match no irq");
    a_soft_cause: assert property (SFR_WR && SFR_ADDR == 8'h33
        && SFR_WDATA[0] |=> SOFT_RESET) else $error("no soft reset");
    a_soft_single: assert property (SOFT_RESET |=> !SOFT_RESET)
        else $error("soft reset too long");
    a_fifo_status: assert property (SFR_RD && SFR_ADDR == 8'h31
        |=> SFR_RDATA[7:1] == {5'h00, $past(TX_SHIFTER_EMPTY),
        $past(TX_LEVEL) == 0}) else $error("fifo status wrong");
    a_dbg_fifo: assert property (SFR_RD && SFR_ADDR == 8'h34
        |=> SFR_RDATA[4:0] == $past(FIFO_STATE)) else $error("dbg wrong");
    a_flag_rsvd: assert property (SFR_RD && SFR_ADDR == 8'h30
        |=> !SFR_RDATA[7]) else $error("reserved flag set");
endmodule // smbesc_chk

// file: smbesc_bus_model.sv
`timescale 1ns/1ps
module smbesc_bus (
    output logic scl,
    output logic sda
);
    // Lines rest high on pull-ups; the clock only runs inside frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Start, n bits with data high, stop; 200 ns a bit
    task automatic frame(input int n);
        #3 sda = 1'b0;
        #100;
        repeat (n) begin
            scl = 1'b0;
            #50 sda = 1'b1;
            #50 scl = 1'b1;
            #100;
        end
        scl = 1'b0;
        #50 sda = 1'b0;
        #50 scl = 1'b1;
        #100 sda = 1'b1;
        #100;
    endtask
endmodule // smbesc_bus

// file: tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
    logic mclk = 0, rst_n = 0, wr = 0, rd = 0, tse = 1;
    logic [7:0] addr = 0, wdata = 0, en = 0, s;
    logic [4:0] rxl = 0, txl = 0, evs = 0, fs = 0;
    logic [3:0] ss = 0;
    logic [2:0] mode = 0;
    logic [1:0] thr = 0;
    wire [7:0] rdata;
    wire scl, sda, irq, lirq, srst, tmo;
    int error_cnt = 0, comparisons = 0, flg;
    // Four-state so an unknown pulse output cannot count as zero
    integer lcnt = 0, tcnt = 0;
    int th[4] = '{1, 4, 8, 13};
    int evm[5] = '{8, 8, 8, 16, 96};
    int tn[4] = '{20, 100, 20, 30};
    // Debug 0 already shows the free bus as idle when first read
    logic [7:0] rv[6] = '{8'h00, 8'h06, 8'h00, 8'h80, 8'h80, 8'h00};
    // Short timeout count keeps the long-timeout case brief
    smbesc_top #(.TIMEOUT_CYC(600), .LW(5)) smbesc_top_inst (
        .MCLK(mclk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .EVENT_ENABLE(en),
        .THRESHOLD_SEL(thr), .RX_LEVEL(rxl), .TX_LEVEL(txl),
        .TX_SHIFTER_EMPTY(tse), .MODE(mode), .ADDRESS_MATCH(evs[4]),
        .RX_PACKAGE_END(evs[3]), .BUS_FAIL(evs[2]),
        .BUS_COLLISION(evs[1]), .DEVICE_ERROR(evs[0]), .FIFO_STATE(fs),
        .SYSTEM_STATE(ss), .SCL_IN(scl), .SDA_IN(sda), .IRQ(irq),
        .LINE_IRQ(lirq), .SOFT_RESET(srst), .TIMEOUT(tmo));
    smbesc_bus smbesc_bus_inst (.scl(scl), .sda(sda));
    initial forever #12.5 mclk = ~mclk;
    always @(negedge mclk) begin
        lcnt += lirq;
        tcnt += tmo;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wreg(input logic [7:0] a, v);
        @(negedge mclk);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, e);
        @(negedge mclk);
        addr = a;
        rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
        `CHK("register", e, rdata)
    endtask
    task automatic pulse(input int k);
        @(negedge mclk);
        evs[k] = 1'b1;
        @(negedge mclk);
        evs = 5'h00;
        repeat (3) @(negedge mclk);
    endtask
    task automatic note(input string t);
        $display("test %s done", t);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(9856));
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rreg(8'(8'h30 + i), rv[i]);
        end
        repeat (4) begin
            s = 8'($urandom);
            wreg(8'h32, s);
            rreg(8'h32, s);
        end
        wreg(8'h36, 8'hff);
        rreg(8'h36, 8'h00);
        note("reset and scratch");
        for (int i = 0; i < 10; i++) begin
            en = i[0] ? 8'hff : 8'h80;
            flg = i[0] ? evm[i / 2] : 0;
            pulse(i / 2);
            rreg(8'h30, 8'(flg));
            `CHK("irq", flg != 0, irq)
            wreg(8'h30, 8'h01);
            rreg(8'h30, 8'(flg));
            wreg(8'h30, 8'(flg));
            rreg(8'h30, 8'h00);
        end
        // Receive ready must trail the address match by one clock
        @(negedge mclk) evs[4] = 1'b1;
        @(negedge mclk) begin
            evs = 5'h00;
            addr = 8'h30;
            rd = 1'b1;
        end
        @(negedge mclk) rd = 1'b0;
        `CHK("match order", 8'h20, rdata)
        rreg(8'h30, 8'h60);
        wreg(8'h30, 8'h60);
        note("events");
        thr = 2'd2;
        txl = 5'd9;
        @(negedge mclk) txl = 5'd7;
        @(negedge mclk) txl = 5'd0;
        @(negedge mclk) rxl = 5'd9;
        rreg(8'h30, 8'h47);
        wreg(8'h30, 8'hff);
        for (int m = 0; m < 8; m++) begin
            mode = 3'(m);
            tse = 1'($urandom);
            rreg(8'h31, {5'h00, tse, 1'b1, m == 5 || m == 7});
        end
        // Each threshold code, crossed from a level sitting on it
        for (int t = 0; t < 4; t++) begin
            @(negedge mclk);
            thr = 2'(t);
            txl = 5'(th[t]);
            rxl = 5'(th[t]);
            wreg(8'h30, 8'hff);
            txl = 5'(th[t] - 1);
            rxl = 5'(th[t] + 1);
            rreg(8'h30, t == 0 ? 8'h07 : 8'h03);
        end
        txl = 5'd0;
        rxl = 5'd0;
        wreg(8'h30, 8'hff);
        note("levels");
        pulse(2);
        s = 8'($urandom);
        wreg(8'h32, s);
        wreg(8'h33, 8'hc1);
        `CHK("soft reset", 1'b1, srst)
        @(negedge mclk);
        `CHK("soft reset", 1'b0, srst)
        `CHK("irq", 1'b0, irq)
        rreg(8'h30, 8'h00);
        rreg(8'h32, s);
        rreg(8'h33, 8'hc0);
        note("soft reset");
        fs = 5'($urandom);
        ss = 4'($urandom);
        for (int m = 0; m < 4; m++) begin
            wreg(8'h33, {2'(m), 6'h00});
            lcnt = 0;
            smbesc_bus_inst.frame(4);
            repeat (8) @(negedge mclk);
            `CHK("line irq", m[0] ? 5 : 2, lcnt)
        end
        rreg(8'h34, {3'b101, fs});
        note("line irq");
        for (int i = 0; i < 4; i++) begin
            wreg(8'h35, {7'h00, i[1]});
            rreg(8'h35, {ss, 3'h0, i[1]});
            tcnt = 0;
            smbesc_bus_inst.frame(tn[i]);
            repeat (8) @(negedge mclk);
            `CHK("timeout", i[0], tcnt)
            rreg(8'h30, i[0] ? 8'h08 : 8'h00);
            wreg(8'h30, 8'hff);
        end
        note("timeout");
        finish_test();
    end
    // About 50 us of tests; a hang ends well after that
    initial begin
        #400000;
        error_cnt++;
        finish_test();
    end
endmodule // tb
bind smbesc_top smbesc_chk #(.LW(LW)) smbesc_chk_inst (.MCLK(MCLK),
    .RST_N(RST_N), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
    .EVENT_ENABLE(EVENT_ENABLE), .TX_LEVEL(TX_LEVEL),
    .TX_SHIFTER_EMPTY(TX_SHIFTER_EMPTY), .ADDRESS_MATCH(ADDRESS_MATCH),
    .BUS_FAIL(BUS_FAIL), .FIFO_STATE(FIFO_STATE), .IRQ(IRQ),
    .SOFT_RESET(SOFT_RESET));
